// File: core/nhrp_defs.vh
`ifndef NHRP_DEFS_VH
`define NHRP_DEFS_VH
// register byte offsets
`define REG_CTRL       8'h00
`define REG_HOP_INIT   8'h04
`define REG_MAX_SDU    8'h08
`define REG_STATUS     8'h0C
`define REG_GOOD_CNT   8'h10
`define REG_ERR_CNT    8'h14
`define REG_HOPX_CNT   8'h18
// control fields
`define CTRL_FWD_BIT   0
`define CTRL_ENC_LSB   1
`define CTRL_RST       32'h0000_0000
`define HOP_INIT_RST   8'h10
`define MAX_SDU_RST    16'h0FFF
// encapsulation modes
`define ENC_NONE       2'h0
`define ENC_LLC        2'h1
`define ENC_NLPID      2'h2
`define LLC_PRE_LEN    4'h8
`define NLPID_PRE_LEN  4'h7
// fixed header layout
`define FIX_LEN        16'h0014
`define POS_HOP        16'h0009
`define POS_CHK_HI     16'h000C
`define POS_CHK_LO     16'h000D
`define PROTO_LONG     16'h0080
`define VER_THIS       8'h01
`define TYPE_ERR_IND   8'h07
`define TYPE_RESEARCH  8'h80
`define ONES_SUM       16'hFFFF
`endif

// File: core/nhrp_fixed_header_engine.v
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "nhrp_defs.vh"
// How it works
// - fixed header is exactly 20 octets, then mandatory part, then optional extensions.
// - extension offset zero: mandatory length is packet size minus 20.
// - extension offset nonzero: mandatory length is offset minus 20.
// - extension length is packet size minus offset; only mandatory part required.
// - LLC/SNAP links carry the AA-AA-03, 00-00-5E, 00-03 prefix.
// - frame relay and X.25 links use NLPID 0x0080 with the same SNAP.
// - unused fields are sent as zero and ignored on receipt.
// - protocol type decodes to NLPID, reserved, forum, experimental or Ethertype.
// - snap field is meaningful only for type 0x0080, else zero and ignored.
// - transmit short form when possible, Ethertype preferred over NLPID.
// - forwarding decrements the hop count by one.
// - forwarded packet with hop count zero is dropped, hop-exceeded error raised.
// - no error indication is raised for a received error indication.
// - replies carry the same initial hop count as own requests.
// - packet size is total octets from fixed header, no encapsulation.
// - checksum is ones-complement IP checksum over the whole packet.
// - hop-only change adjusts checksum incrementally, otherwise full recompute.
// - offset zero means no extensions, else offset of first extension.
// - version decodes to multicast, this protocol, reserved, forum or experimental.
// - version 1 types 1 to 7 are the seven defined messages.
// - types 128 to 255 are reserved, never defined messages.
// - built packets never exceed the configured maximum SDU size.
// - type/length bit 7 must be zero; bit 6 format; low six bits length.
module nhrp_fixed_header_engine (
  input  wire         clock_in,         // 100 MHz clock
  input  wire         nrst_in,          // sync reset, low
  input  wire         hsel_in,          // ahb select
  input  wire [31:0]  haddr_in,         // ahb address
  input  wire [1:0]   htrans_in,        // ahb transfer type
  input  wire         hwrite_in,        // ahb write
  input  wire [2:0]   hsize_in,         // ahb size
  input  wire [31:0]  hwdata_in,        // ahb write data
  input  wire         hready_in,        // ahb bus ready
  output reg  [31:0]  hrdata_out,       // ahb read data
  output wire         hreadyout_out,    // ahb slave ready
  output wire         hresp_out,        // ahb response
  input  wire         rx_valid_in,      // link octet valid
  input  wire [7:0]   rx_data_in,       // link octet
  input  wire         rx_last_in,       // last octet of frame
  output reg          fwd_valid_out,    // forward octet valid
  output reg  [7:0]   fwd_data_out,     // forward octet
  output reg          fwd_last_out,     // forward last octet
  output reg          fwd_drop_out,     // discard forwarded frame
  output reg  [1:0]   fwd_part_out,     // 0 fixed 1 mandatory 2 ext
  output reg          hdr_valid_out,    // good header pulse
  output reg          hdr_err_out,      // bad packet pulse
  output reg          err_ind_out,      // hop exceeded pulse
  output reg  [159:0] hdr_fields_out,   // fixed header, snap zeroed in short form
  output reg  [2:0]   proto_class_out,  // protocol type class
  output reg  [2:0]   version_class_out,// version class
  output reg          type_known_out,   // defined message type
  output reg          type_research_out,// type 128..255
  output reg  [15:0]  mand_len_out,     // mandatory part length
  output reg  [15:0]  ext_len_out,      // extension part length
  input  wire         bld_start_in,     // build a header
  input  wire [15:0]  bld_afn_in,       // address family
  input  wire         bld_ether_ok_in,  // ethertype code exists
  input  wire [15:0]  bld_ether_in,     // ethertype code
  input  wire         bld_nlpid_ok_in,  // nlpid code exists
  input  wire [7:0]   bld_nlpid_in,     // nlpid code
  input  wire [39:0]  bld_snap_in,      // long form snap id
  input  wire [15:0]  bld_pktsz_in,     // total packet size
  input  wire [15:0]  bld_extoff_in,    // extension offset
  input  wire [7:0]   bld_ptype_in,     // packet type
  input  wire [7:0]   bld_shtl_in,      // source addr type/len
  input  wire [7:0]   bld_sstl_in,      // source subaddr type/len
  input  wire [15:0]  bld_body_sum_in,  // sum of octets after header
  output reg          bld_valid_out,    // built octet valid
  output reg  [7:0]   bld_data_out,     // built octet
  output reg          bld_last_out,     // last header octet
  input  wire         bld_ready_in,     // sink takes octet
  output wire         bld_busy_out,     // builder active
  output reg          bld_err_out       // refused build pulse
);
  ////////////////////////////////////////////////////////////////
  function [15:0] oc_add;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] s;
    begin
      s      = {1'b0, a} + {1'b0, b};
      oc_add = s[15:0] + {15'h0, s[16]};
    end
  endfunction

  function [7:0] pre_byte;
    input [1:0] mode;
    input [3:0] idx;
    reg   [63:0] t;
    begin
      t = (mode == `ENC_LLC) ? 64'hAAAA_0300_005E_0003 : 64'h0080_0000_5E00_0300;
      pre_byte = t[63 - 8 * idx -: 8];
    end
  endfunction

  function [3:0] pre_len;
    input [1:0] mode;
    begin
      pre_len = (mode == `ENC_LLC) ? `LLC_PRE_LEN :
                (mode == `ENC_NLPID) ? `NLPID_PRE_LEN : 4'h0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  reg  [31:0] ctrl_r;
  reg  [7:0]  hop_init_r;
  reg  [15:0] max_sdu_r;
  reg  [31:0] good_cnt_r;
  reg  [31:0] err_cnt_r;
  reg  [31:0] hopx_cnt_r;
  reg         wr_pend_r;
  reg         rd_pend_r;
  reg  [7:0]  addr_r;
  wire        ahb_go   = hsel_in & htrans_in[1] & hready_in;
  wire        fwd_mode = ctrl_r[`CTRL_FWD_BIT];
  wire [1:0]  enc_mode = ctrl_r[`CTRL_ENC_LSB +: 2];

  assign hreadyout_out = ~rd_pend_r;
  assign hresp_out     = 1'b0;

  always @(posedge clock_in) begin
    if (!nrst_in) begin
      wr_pend_r  <= 1'b0;
      rd_pend_r  <= 1'b0;
      addr_r     <= 8'h00;
      hrdata_out <= 32'h0000_0000;
      ctrl_r     <= `CTRL_RST;
      hop_init_r <= `HOP_INIT_RST;
      max_sdu_r  <= `MAX_SDU_RST;
    end else begin
      wr_pend_r <= ahb_go & hwrite_in;
      rd_pend_r <= ahb_go & ~hwrite_in;
      if (ahb_go)
        addr_r <= haddr_in[7:0];
      if (wr_pend_r) begin
        case (addr_r)
          `REG_CTRL:     ctrl_r     <= {29'h0, hwdata_in[2:0]};
          `REG_HOP_INIT: hop_init_r <= hwdata_in[7:0];
          `REG_MAX_SDU:  max_sdu_r  <= hwdata_in[15:0];
          default:       ;
        endcase
      end
      if (rd_pend_r) begin
        case (addr_r)
          `REG_CTRL:     hrdata_out <= ctrl_r;
          `REG_HOP_INIT: hrdata_out <= {24'h0, hop_init_r};
          `REG_MAX_SDU:  hrdata_out <= {16'h0, max_sdu_r};
          `REG_STATUS:   hrdata_out <= {23'h0, type_research_out, type_known_out,
                                        version_class_out, proto_class_out, bld_busy_out};
          `REG_GOOD_CNT: hrdata_out <= good_cnt_r;
          `REG_ERR_CNT:  hrdata_out <= err_cnt_r;
          `REG_HOPX_CNT: hrdata_out <= hopx_cnt_r;
          default:       hrdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // receive: strip prefix, gather header, sum words, patch hop
  reg  [3:0]   pre_cnt_r;
  reg          enc_err_r;
  reg  [15:0]  cnt_r;
  reg  [159:0] hdr_r;
  reg  [15:0]  sum_r;
  reg  [7:0]   hi_r;
  reg  [7:0]   hold_r;
  reg          hold_v_r;
  reg  [1:0]   hold_part_r;
  reg          flush_r;
  reg          flush_drop_r;
  wire         in_pre  = pre_cnt_r < pre_len(enc_mode);
  wire         take    = rx_valid_in & ~in_pre;
  wire [15:0]  cnt_nxt = cnt_r + 16'h0001;
  wire [7:0]   hop_rx  = hdr_r[159 - 8 * 9 -: 8];
  wire [15:0]  ext_rx  = hdr_r[159 - 8 * 14 -: 16];
  wire [15:0]  size_rx = hdr_r[159 - 8 * 10 -: 16];
  wire [15:0]  mand_end = (ext_rx == 16'h0000) ? size_rx : ext_rx;
  wire [15:0]  sum_end = sum_r;
  wire [15:0]  chk_new = ~oc_add(~{hold_r, rx_data_in}, 16'hFFFE);
  // octet 9 is live at the hop slot, four octets up at the checksum slot
  wire         patch   = fwd_mode & (((cnt_r == `POS_HOP) ? rx_data_in : hdr_r[31:24]) != 8'h00);
  wire [1:0]   part_now = (cnt_r < `FIX_LEN) ? 2'd0 :
                          (cnt_r < mand_end) ? 2'd1 : 2'd2;

  reg          bad;
  reg  [7:0]   vr;
  reg  [7:0]   tp;
  always @* begin
    vr  = hdr_r[159 - 8 * 16 -: 8];
    tp  = hdr_r[159 - 8 * 17 -: 8];
    bad = enc_err_r | (cnt_nxt < `FIX_LEN) | (cnt_nxt != size_rx)
          | (oc_add(sum_end, (cnt_nxt[0] ? {rx_data_in, 8'h00} : {hi_r, rx_data_in}))
             != `ONES_SUM)
          | ((ext_rx != 16'h0000) & ((ext_rx < `FIX_LEN) | (ext_rx > size_rx)))
          | hdr_r[7] | hdr_r[15];
  end

  always @(posedge clock_in) begin
    if (!nrst_in) begin
      pre_cnt_r <= 4'h0;
      enc_err_r <= 1'b0;
      cnt_r <= 16'h0000;
      hdr_r <= 160'h0;
      sum_r <= 16'h0000;
      hi_r <= 8'h00;
      hold_r <= 8'h00;
      hold_v_r <= 1'b0;
      hold_part_r <= 2'd0;
      flush_r <= 1'b0;
      flush_drop_r <= 1'b0;
      fwd_valid_out <= 1'b0;
      fwd_data_out <= 8'h00;
      fwd_last_out <= 1'b0;
      fwd_drop_out <= 1'b0;
      fwd_part_out <= 2'd0;
      hdr_valid_out <= 1'b0;
      hdr_err_out <= 1'b0;
      err_ind_out <= 1'b0;
      hdr_fields_out <= 160'h0;
      proto_class_out <= 3'd0;
      version_class_out <= 3'd0;
      type_known_out <= 1'b0;
      type_research_out <= 1'b0;
      mand_len_out <= 16'h0000;
      ext_len_out <= 16'h0000;
      good_cnt_r <= 32'h0;
      err_cnt_r <= 32'h0;
      hopx_cnt_r <= 32'h0;
    end else begin
      hdr_valid_out <= 1'b0;
      hdr_err_out <= 1'b0;
      err_ind_out <= 1'b0;
      flush_r <= 1'b0;
      fwd_valid_out <= (take & hold_v_r) | flush_r;
      fwd_last_out <= flush_r;
      fwd_drop_out <= flush_r & flush_drop_r;
      if (flush_r | (take & hold_v_r)) begin
        fwd_data_out <= hold_r;
        fwd_part_out <= hold_part_r;
        if (take & (cnt_r == `POS_CHK_LO) & patch)
          fwd_data_out <= chk_new[15:8];
      end
      if (rx_valid_in & in_pre) begin
        pre_cnt_r <= pre_cnt_r + 4'h1;
        if (rx_data_in != pre_byte(enc_mode, pre_cnt_r))
          enc_err_r <= 1'b1;
      end
      if (take) begin
        hold_v_r <= ~rx_last_in;
        hold_part_r <= part_now;
        hold_r <= rx_data_in;
        if ((cnt_r == `POS_HOP) & patch)
          hold_r <= rx_data_in - 8'h01;
        if ((cnt_r == `POS_CHK_LO) & patch)
          hold_r <= chk_new[7:0];
        if (cnt_r < `FIX_LEN)
          hdr_r <= {hdr_r[151:0], rx_data_in};
        if (cnt_r[0])
          sum_r <= oc_add(sum_r, {hi_r, rx_data_in});
        else
          hi_r <= rx_data_in;
        cnt_r <= cnt_nxt;
        if (rx_last_in) begin
          flush_r <= 1'b1;
          flush_drop_r <= bad | (fwd_mode & (hop_rx == 8'h00));
          cnt_r <= 16'h0000;
          sum_r <= 16'h0000;
          pre_cnt_r <= 4'h0;
          enc_err_r <= 1'b0;
          hdr_err_out <= bad;
          hdr_valid_out <= ~bad;
          if (bad)
            err_cnt_r <= err_cnt_r + 32'h1;
          else
            good_cnt_r <= good_cnt_r + 32'h1;
          if (~bad & fwd_mode & (hop_rx == 8'h00) & (tp != `TYPE_ERR_IND)) begin
            err_ind_out <= 1'b1;
            hopx_cnt_r <= hopx_cnt_r + 32'h1;
          end
          hdr_fields_out <= hdr_r;
          if (hdr_r[159 - 16 -: 16] != `PROTO_LONG)
            hdr_fields_out[159 - 32 -: 40] <= 40'h0;
          proto_class_out <= (hdr_r[143:136] == 8'h00) ? 3'd0 :
                             (hdr_r[143:136] < 8'h04) ? 3'd1 :
                             (hdr_r[143:136] == 8'h04) ? 3'd2 :
                             (hdr_r[143:136] == 8'h05) ? 3'd3 : 3'd4;
          version_class_out <= (vr == 8'h00) ? 3'd0 : (vr == `VER_THIS) ? 3'd1 :
                               (vr < 8'hF0) ? 3'd2 : (vr < 8'hFF) ? 3'd3 : 3'd4;
          type_known_out <= (vr == `VER_THIS) & (tp != 8'h00) & (tp <= `TYPE_ERR_IND);
          type_research_out <= tp >= `TYPE_RESEARCH;
          mand_len_out <= mand_end - `FIX_LEN;
          ext_len_out <= (ext_rx == 16'h0000) ? 16'h0000 : size_rx - ext_rx;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // builder: prefix then fixed header with full checksum
  localparam [1:0] B_IDLE = 2'd0;
  localparam [1:0] B_PRE  = 2'd1;
  localparam [1:0] B_HDR  = 2'd2;
  reg  [1:0]   bst_r;
  reg  [4:0]   bidx_r;
  reg  [159:0] bhdr_r;
  reg  [15:0]  bsum_r;
  reg  [1:0]   benc_r;
  wire         bload = ~bld_valid_out | bld_ready_in;
  wire [15:0]  bchk  = ~oc_add(bhdr_r[159:144], bsum_r);
  assign bld_busy_out = bst_r != B_IDLE;

  reg  [15:0]  acc;
  reg  [15:0]  ptype_sel;
  reg  [39:0]  snap_sel;
  reg  [159:0] bhdr_nxt;
  integer      k;
  always @* begin
    if (bld_ether_ok_in) begin
      ptype_sel = bld_ether_in;
      snap_sel = 40'h0;
    end else if (bld_nlpid_ok_in) begin
      ptype_sel = {8'h00, bld_nlpid_in};
      snap_sel = 40'h0;
    end else begin
      ptype_sel = `PROTO_LONG;
      snap_sel = bld_snap_in;
    end
    bhdr_nxt = {bld_afn_in, ptype_sel, snap_sel, hop_init_r,
                bld_pktsz_in, 16'h0000, bld_extoff_in, `VER_THIS, bld_ptype_in,
                bld_shtl_in, bld_sstl_in};
    acc = bld_body_sum_in;
    for (k = 0; k < 10; k = k + 1)
      acc = oc_add(acc, bhdr_nxt[159 - 16 * k -: 16]);
  end

  always @(posedge clock_in) begin
    if (!nrst_in) begin
      bst_r <= B_IDLE;
      bidx_r <= 5'd0;
      bhdr_r <= 160'h0;
      bsum_r <= 16'h0000;
      benc_r <= `ENC_NONE;
      bld_valid_out <= 1'b0;
      bld_data_out <= 8'h00;
      bld_last_out <= 1'b0;
      bld_err_out <= 1'b0;
    end else begin
      bld_err_out <= 1'b0;
      if (bld_valid_out & bld_ready_in)
        bld_valid_out <= 1'b0;
      case (bst_r)
        B_IDLE: begin
          if (bld_start_in) begin
            if ((bld_pktsz_in > max_sdu_r) | (bld_pktsz_in < `FIX_LEN))
              bld_err_out <= 1'b1;
            else begin
              bhdr_r <= bhdr_nxt;
              bsum_r <= oc_add(acc, ~bhdr_nxt[159:144]);
              benc_r <= enc_mode;
              bidx_r <= 5'd0;
              bst_r <= (enc_mode == `ENC_NONE) ? B_HDR : B_PRE;
            end
          end
        end
        B_PRE: begin
          if (bload) begin
            bld_valid_out <= 1'b1;
            bld_last_out <= 1'b0;
            bld_data_out <= pre_byte(benc_r, bidx_r[3:0]);
            bidx_r <= bidx_r + 5'd1;
            if (bidx_r[3:0] == pre_len(benc_r) - 4'h1) begin
              bidx_r <= 5'd0;
              bst_r <= B_HDR;
            end
          end
        end
        B_HDR: begin
          if (bload) begin
            bld_valid_out <= 1'b1;
            bld_last_out <= bidx_r == 5'd19;
            bld_data_out <= (bidx_r == 5'd12) ? bchk[15:8] :
                            (bidx_r == 5'd13) ? bchk[7:0] :
                            bhdr_r[159 - 8 * bidx_r -: 8];
            bidx_r <= bidx_r + 5'd1;
            if (bidx_r == 5'd19)
              bst_r <= B_IDLE;
          end
        end
        default: bst_r <= B_IDLE;
      endcase
    end
  end

endmodule // nhrp_fixed_header_engine
`default_nettype wire

// File: verif/link_peer.sv
`timescale 1ns/1ps
`default_nettype none
module link_peer (
  input  wire logic       clock_in,   // clock
  output logic            valid_out,  // octet valid
  output logic [7:0]      data_out,   // octet
  output logic            last_out,   // final octet
  input  wire logic       bv_in,      // built octet valid
  input  wire logic [7:0] bd_in,      // built octet
  output logic            ready_out   // built octet taken
);
  logic [7:0] frm [0:71];
  logic [7:0] got [$];
  logic       slow = 1'b0;
  logic [3:0] ph = 4'h0;
  initial begin
    valid_out = 1'b0;
    data_out = 8'h00;
    last_out = 1'b0;
    ready_out = 1'b1;
  end
  // frame back to back
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      valid_out <= 1'b1;
      data_out <= frm[i];
      last_out <= (i == n - 1);
      @(posedge clock_in);
    end
    valid_out <= 1'b0;
    last_out <= 1'b0;
    data_out <= ~frm[n - 1];
  endtask
  // sink stalls every other cycle when slow
  always @(posedge clock_in) begin
    if (bv_in && ready_out)
      got.push_back(bd_in);
    ph <= ph + 4'h1;
    ready_out <= !slow || ph[0];
  end
endmodule // link_peer
`default_nettype wire

// File: verif/nhrp_fixed_header_engine_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "nhrp_defs.vh"
module hdr_checker (
  input wire logic         clock_in,        // clock
  input wire logic         nrst_in,         // sync reset, low
  input wire logic         fwd_valid_out,   // forward octet valid
  input wire logic         fwd_last_out,    // forward last octet
  input wire logic         fwd_drop_out,    // forward discard
  input wire logic         hdr_valid_out,   // good header pulse
  input wire logic         hdr_err_out,     // bad packet pulse
  input wire logic         err_ind_out,     // hop exceeded pulse
  input wire logic [159:0] hdr_fields_out,  // header octets, short form snap zeroed
  input wire logic [15:0]  mand_len_out,    // mandatory length
  input wire logic [15:0]  ext_len_out,     // extension length
  input wire logic         bld_start_in,    // build request
  input wire logic [15:0]  bld_pktsz_in,    // build size
  input wire logic         bld_busy_out,    // builder active
  input wire logic         bld_err_out,     // build refused
  input wire logic         bld_valid_out,   // built octet valid
  input wire logic [7:0]   bld_data_out,    // built octet
  input wire logic         bld_ready_in     // sink ready
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  wire [7:0]  hop = hdr_fields_out[87:80];
  wire [7:0]  typ = hdr_fields_out[23:16];
  wire [15:0] pro = hdr_fields_out[143:128];
  wire [15:0] sz  = hdr_fields_out[79:64];
  wire [15:0] xo  = hdr_fields_out[47:32];
  sequence drop_end;
    fwd_drop_out && fwd_last_out && fwd_valid_out;
  endsequence
  ////////////////////////////////////////////////////////////////
  status_excl_a: assert property (!(hdr_valid_out && hdr_err_out))
    else $error("valid and error pulses together");
  err_drop_a: assert property (hdr_err_out |=> drop_end)
    else $error("bad packet not dropped");
  hop_expiry_a: assert property (err_ind_out |-> (hop == 8'h00 && typ != `TYPE_ERR_IND) ##1 drop_end)
    else $error("error indication without cause");
  mand_plain_a: assert property (hdr_valid_out && xo == 16'h0000 |-> mand_len_out == sz - `FIX_LEN)
    else $error("mandatory length wrong without extensions");
  mand_ext_a: assert property (hdr_valid_out && xo != 16'h0000 |-> mand_len_out == xo - `FIX_LEN && ext_len_out == sz - xo)
    else $error("part lengths wrong with extensions");
  snap_zero_a: assert property (hdr_valid_out && pro != `PROTO_LONG |-> hdr_fields_out[127:88] == 40'h0)
    else $error("short form snap not ignored");
  size_floor_a: assert property (hdr_valid_out |-> sz >= `FIX_LEN && (xo == 16'h0000 || (xo >= `FIX_LEN && xo <= sz)))
    else $error("inconsistent header accepted");
  build_refuse_a: assert property (bld_start_in && !bld_busy_out && bld_pktsz_in < `FIX_LEN |=> bld_err_out && !bld_valid_out)
    else $error("short build not refused");
  build_hold_a: assert property (bld_valid_out && !bld_ready_in |=> bld_valid_out && $stable(bld_data_out))
    else $error("built octet dropped before taken");
endmodule // hdr_checker
bind nhrp_fixed_header_engine hdr_checker chk (.*);
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "nhrp_defs.vh"
module tb_top;
  logic        clock_in = 0, nrst_in = 0, hsel_in = 0, hwrite_in = 0, bld_start_in = 0;
  logic        bld_ether_ok_in = 0, bld_nlpid_ok_in = 0, sv, se, si, sd, be;
  logic [1:0]  htrans_in = 0;
  logic [2:0]  hsize_in = 3'h2;
  logic [7:0]  bld_nlpid_in = 8'hCC, bld_ptype_in = 8'h01, bld_shtl_in = 8'h14, bld_sstl_in = 8'h00;
  logic [15:0] bld_afn_in = 16'h0003, bld_ether_in = 16'h0800, bld_pktsz_in = 16'h0018;
  logic [15:0] bld_extoff_in = 16'h0000, bld_body_sum_in = 16'h1234;
  logic [31:0] haddr_in = 0, hwdata_in = 0, q;
  logic [39:0] bld_snap_in = 40'h0000000800;
  logic [7:0]  pk [0:63];
  logic [7:0]  fw [$];
  logic [39:0] dec [0:6] = '{40'h00CC010106, 40'h0200000720, 40'h0450050248, 40'h0550F5806D,
                             40'h0800FFFF91, 40'h0800010884, 40'h0080010706};
  int          n_errors = 0, samples_checked = 0, cyc = 0;
  wire         hreadyout_out, hresp_out, fwd_valid_out, fwd_last_out, fwd_drop_out, hdr_valid_out, hdr_err_out;
  wire         err_ind_out, type_known_out, type_research_out, bld_valid_out, bld_last_out, bld_busy_out;
  wire         bld_err_out, rx_valid_in, rx_last_in, bld_ready_in;
  wire [1:0]   fwd_part_out;
  wire [2:0]   proto_class_out, version_class_out;
  wire [7:0]   fwd_data_out, bld_data_out, rx_data_in;
  wire [15:0]  mand_len_out, ext_len_out;
  wire [31:0]  hrdata_out;
  wire [159:0] hdr_fields_out;
  wire         hready_in = hreadyout_out;
  localparam logic [63:0] LLC = 64'hAAAA0300005E0003, NLP = 64'h008000005E000300;
  nhrp_fixed_header_engine dut (.*);
  link_peer peer (.clock_in(clock_in), .valid_out(rx_valid_in), .data_out(rx_data_in), .last_out(rx_last_in),
                  .bv_in(bld_valid_out), .bd_in(bld_data_out), .ready_out(bld_ready_in));
  initial forever #5 clock_in = ~clock_in;
  ////////////////////////////////////////////////////////////////
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (hdr_valid_out) sv <= 1'b1;
    if (hdr_err_out) se <= 1'b1;
    if (err_ind_out) si <= 1'b1;
    if (fwd_drop_out) sd <= 1'b1;
    if (bld_err_out) be <= 1'b1;
    if (fwd_valid_out) fw.push_back(fwd_data_out);
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [63:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, d);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= a;
    hwrite_in <= w;
    do @(posedge clock_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge clock_in); while (hreadyout_out !== 1'b1);
    q = hrdata_out;
  endtask
  function automatic logic [15:0] csum(input int sz);
    int s = 0;
    for (int i = 0; i < sz; i += 2) s += {pk[i], pk[i + 1]};
    s = s[15:0] + s[31:16];
    s = s[15:0] + s[31:16];
    return ~s[15:0];
  endfunction
  // snap octet 7 nonzero to test masking
  task automatic send(input logic [15:0] pro, sz, xo, input logic [7:0] hop, ver, typ,
                      input logic [63:0] pf, input int np, input logic bad);
    for (int i = 0; i < 64; i++) pk[i] = (i < 20) ? 8'h00 : i[7:0];
    {pk[0], pk[1], pk[2], pk[3], pk[7], pk[8], pk[9]} = {16'h0003, pro, 16'h0800, hop};
    {pk[10], pk[11], pk[14], pk[15], pk[16], pk[17], pk[18]} = {sz, xo, ver, typ, bld_shtl_in};
    {pk[12], pk[13]} = csum(sz) ^ {15'h0, bad};
    for (int i = 0; i < np + sz; i++) peer.frm[i] = (i < np) ? pf[63 - 8 * i -: 8] : pk[i - np];
    {sv, se, si, sd} = 4'h0;
    fw = {};
    peer.send(np + sz);
    repeat (4) @(posedge clock_in);
  endtask
  task automatic build(input logic [15:0] sz);
    be = 1'b0;
    peer.got = {};
    bld_pktsz_in <= sz;
    bld_start_in <= 1'b1;
    @(posedge clock_in);
    bld_start_in <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock_in);
    nrst_in <= 1'b1;
    @(posedge clock_in);
    ahb(1'b0, `REG_HOP_INIT, 0);
    chk(q, `HOP_INIT_RST);
    ahb(1'b0, `REG_MAX_SDU, 0);
    chk(q, `MAX_SDU_RST);
    ahb(1'b1, 32'h1C, 32'hFFFFFFFF);
    ahb(1'b0, 32'h1C, 0);
    chk({q, hresp_out}, 0);
    $display("test registers done");
    foreach (dec[k]) begin
      send(dec[k][39:24], 16'h0018, 16'h0000, 8'h03, dec[k][23:16], dec[k][15:8], 64'h0, 0, 1'b0);
      chk({sv, se, mand_len_out}, {2'b10, 16'h0004});
      chk({proto_class_out, version_class_out, type_known_out, type_research_out}, dec[k][7:0]);
    end
    for (int t = 1; t < 8; t++) begin
      send(16'h0800, 16'h0018, 16'h0000, 8'h03, 8'h01, t[7:0], 64'h0, 0, 1'b0);
      chk(type_known_out, 1'b1);
    end
    send(16'h0800, 16'h0020, 16'h0018, 8'h03, 8'h01, 8'h01, 64'h0, 0, 1'b0);
    chk({sv, mand_len_out, ext_len_out}, {1'b1, 16'h0004, 16'h0008});
    send(16'h0800, 16'h0018, 16'h0010, 8'h03, 8'h01, 8'h01, 64'h0, 0, 1'b0);
    chk({sv, se}, 2'b01);
    send(16'h0800, 16'h0018, 16'h0000, 8'h03, 8'h01, 8'h01, 64'h0, 0, 1'b1);
    chk({se, sd}, 2'b11);
    send(16'h0800, 16'h0010, 16'h0000, 8'h03, 8'h01, 8'h01, 64'h0, 0, 1'b0);
    chk(se, 1'b1);
    bld_shtl_in = 8'h94;
    send(16'h0800, 16'h0018, 16'h0000, 8'h03, 8'h01, 8'h01, 64'h0, 0, 1'b0);
    chk(se, 1'b1);
    bld_shtl_in = 8'h14;
    $display("test receive checks done");
    ahb(1'b1, `REG_CTRL, 32'h1);
    send(16'h0800, 16'h0018, 16'h0000, 8'h05, 8'h01, 8'h01, 64'h0, 0, 1'b0);
    pk[9] = 8'h04;
    {pk[12], pk[13]} = 16'h0000;
    chk({fw[9], fw[12], fw[13], sd}, {8'h04, csum(24), 1'b0});
    send(16'h0800, 16'h0018, 16'h0000, 8'h00, 8'h01, 8'h01, 64'h0, 0, 1'b0);
    chk({sd, si}, 2'b11);
    send(16'h0800, 16'h0018, 16'h0000, 8'h00, 8'h01, `TYPE_ERR_IND, 64'h0, 0, 1'b0);
    chk({sd, si}, 2'b10);
    $display("test forwarding done");
    ahb(1'b1, `REG_CTRL, 32'h2);
    send(16'h0800, 16'h0018, 16'h0000, 8'h03, 8'h01, 8'h01, LLC, 8, 1'b0);
    chk({sv, se}, 2'b10);
    send(16'h0800, 16'h0018, 16'h0000, 8'h03, 8'h01, 8'h01, NLP, 7, 1'b0);
    chk({sv, se}, 2'b01);
    ahb(1'b1, `REG_CTRL, 32'h4);
    send(16'h0800, 16'h0018, 16'h0000, 8'h03, 8'h01, 8'h01, NLP, 7, 1'b0);
    chk({sv, se}, 2'b10);
    $display("test encapsulation done");
    ahb(1'b1, `REG_CTRL, 32'h2);
    ahb(1'b1, `REG_HOP_INIT, 32'h20);
    peer.slow = 1'b1;
    for (int i = 0; i < 3; i++) begin
      bld_ether_ok_in <= (i == 0);
      bld_nlpid_ok_in <= (i < 2);
      bld_ether_in <= 16'h0800 + i[15:0];
      bld_snap_in <= 40'h0000000800 + i[39:0];
      bld_ptype_in <= i[7:0] + 8'h01;
      bld_body_sum_in <= 16'h1234 + i[15:0];
      build(16'h0018);
      while (peer.got.size() < 28) @(posedge clock_in);
      for (int j = 0; j < 8; j++) chk(peer.got[j], LLC[63 - 8 * j -: 8]);
      for (int j = 0; j < 20; j++) pk[j] = peer.got[8 + j];
      {pk[20], pk[21], pk[22], pk[23]} = {bld_body_sum_in, 16'h0000};
      chk({pk[2], pk[3]}, (i == 0) ? 16'h0800 : (i == 1) ? 16'h00CC : 16'h0080);
      chk({pk[4], pk[5], pk[6], pk[7], pk[8]}, (i == 2) ? 40'h0000000802 : 40'h0);
      chk({pk[9], pk[10], pk[11], pk[16], pk[17]}, {8'h20, 16'h0018, 8'h01, i[7:0] + 8'h01});
      chk(csum(24), 16'h0000);
    end
    ahb(1'b1, `REG_MAX_SDU, 32'h40);
    for (int k = 0; k < 3; k++) begin
      build((k == 0) ? 16'h0041 : (k == 1) ? 16'h0013 : 16'h0040);
      repeat (80) @(posedge clock_in);
      chk({be, peer.got.size() != 0}, (k < 2) ? 2'b10 : 2'b01);
    end
    $display("test builder done");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
